// file: spc_pkg.sv
/*
  Package for the system power control block: states and timing counts.
  Assumes a single 40 MHz clock domain.
*/
package spc_pkg;
  typedef enum logic [3:0] {
    SPC_ST_RESET = 4'h1,
    SPC_ST_WAKE = 4'h2,
    SPC_ST_RUN = 4'h4,
    SPC_ST_SLEEP = 4'h8
  } spc_state_t;
  // Select pulse length before release (SPI latch on falling edge)
  localparam int SPC_CS_PULSE_NS = 1000;
  localparam int SPC_CLK_PERIOD_NS = 25;
  localparam logic [7:0] SPC_CS_CYCLES =
    8'((SPC_CS_PULSE_NS + SPC_CLK_PERIOD_NS - 1) / SPC_CLK_PERIOD_NS);
  localparam int SPC_SYNC_STAGES = 2;
endpackage

// file: spc_supply_model.sv
/* Supply model: switched rail status.
   Assumes i_off marks system power-down. */
`timescale 1ns/1ps
module spc_supply_model (
  input wire logic i_clk,
  input wire logic i_select,
  input wire logic i_off,
  output logic o_rail = 1'h0,
  output int o_latch_cnt = 0
);
  logic sel_d = 1'h0;
  always @(posedge i_clk) begin
    sel_d <= i_select;
    if (sel_d && !i_select) o_latch_cnt <= o_latch_cnt + 1;
  end
  always @(posedge i_clk)
    if (i_off) o_rail <= 1'h0;
    else if (i_select) o_rail <= 1'h1;
endmodule

// file: spc_sync.sv
/*
  Two-flop synchroniser for a bus of independent level inputs.
  Assumes the bits are unrelated; no bus coherency is implied.
*/
`timescale 1ns/1ps
module spc_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Pins in, levels out
  spc_sync_if.sync bus
);
  logic [5:0] meta_reg;
  logic [5:0] clean_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_reg <= 6'h00;
      clean_reg <= 6'h00;
    end else begin
      meta_reg <= bus.raw;
      clean_reg <= meta_reg;
    end
  end

  assign bus.clean = clean_reg;
endmodule

// file: spc_sync_if.sv
/*
  Interface carrying raw pins into the synchroniser and clean levels out.
  Assumes one clock domain on the consuming side.
*/
`timescale 1ns/1ps
interface spc_sync_if;
  logic [5:0] raw;
  logic [5:0] clean;
  modport src (output raw, input clean);
  modport sync (input raw, output clean);
endinterface

// file: spc_top.sv
/*
  System power control: on-button and wake requests drive the supply
  select, power-good and supply alerts become events for software.
  Assumes all pin inputs are asynchronous and i_clk is the standby clock.
*/
// What this block does
// - On-button press raises the supply select to request system power.
// - Supply select never rises from off while power good is low.
// - Supply alert pulses become a low-priority event for software.
// - Power good falling while on flags a high-priority emergency.
// - Core reset input resets the core separately from power-on reset.
// - After power-on reset, stay off until the on-button is pressed.
`timescale 1ns/1ps
module spc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Reset pins, active low
  input wire logic i_pon_n,
  input wire logic i_core_reset_n,
  // Supply pins
  input wire logic i_on_button,
  input wire logic i_supply_good,
  input wire logic i_supply_event,
  input wire logic i_switched_rail_status,
  // Requests from the system
  input wire logic i_wake_irq,
  input wire logic i_sleep_req,
  input wire logic i_event_clear,
  input wire logic i_emerg_clear,
  // Outputs
  output logic o_supply_select,
  output logic o_core_reset,
  output logic o_running,
  output logic o_supply_event_pend,
  output logic o_emergency_pend
);
  import spc_pkg::*;

  spc_sync_if sif ();
  spc_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .bus(sif)
  );
  assign sif.raw = {i_pon_n, i_core_reset_n, i_on_button, i_supply_good,
                    i_supply_event, i_switched_rail_status};

  wire pon_n_s = sif.clean[5];
  wire core_n_s = sif.clean[4];
  wire button_s = sif.clean[3];
  wire good_s = sif.clean[2];
  wire event_s = sif.clean[1];
  wire rail_s = sif.clean[0];

  spc_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic good_d_reg, event_d_reg, button_d_reg;
  logic sel_reg, sel_next;
  logic ev_reg, ev_next;
  logic em_reg, em_next;
  logic core_rst_reg, core_rst_next;
  logic run_reg, run_next;

  // Power-on reset is a full reset of control state
  wire full_rst = i_srst | ~pon_n_s;
  wire st_run = (state_reg == SPC_ST_RUN);
  wire button_rise = button_s & ~button_d_reg;
  wire wake_req = (button_rise | i_wake_irq) & good_s;
  wire event_rise = event_s & ~event_d_reg;
  // Only a loss while running is an emergency, not a dead supply at rest
  wire good_fall = good_d_reg & ~good_s & st_run;
  wire cnt_done = (cnt_reg == 8'h00);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sel_next = 1'b0;
    case (state_reg)
      SPC_ST_RESET: begin
        // First wake only from the button, not from interrupts
        if (button_rise & good_s) begin
          state_next = SPC_ST_WAKE;
          cnt_next = SPC_CS_CYCLES;
        end
      end
      SPC_ST_SLEEP: begin
        if (wake_req) begin
          state_next = SPC_ST_WAKE;
          cnt_next = SPC_CS_CYCLES;
        end
      end
      SPC_ST_WAKE: begin
        sel_next = 1'b1;
        if (!cnt_done) begin
          cnt_next = cnt_reg - 8'h01;
        end else if (rail_s) begin
          state_next = SPC_ST_RUN;
          sel_next = 1'b0;
        end
        // Power good lost mid-request: abandon the wake
        if (!good_s) begin
          state_next = SPC_ST_SLEEP;
          sel_next = 1'b0;
        end
      end
      SPC_ST_RUN: begin
        if (i_sleep_req) begin
          state_next = SPC_ST_SLEEP;
        end
      end
      default: begin
        state_next = SPC_ST_RESET;
      end
    endcase
  end

  // Set wins over a clear in the same cycle
  assign ev_next = event_rise | (ev_reg & ~i_event_clear);
  assign em_next = good_fall | (em_reg & ~i_emerg_clear);
  // Power-on reset holds the core too, as it has no supply yet
  assign core_rst_next = ~core_n_s | ~pon_n_s;
  // From the next state, so running rises as select falls
  assign run_next = (state_next == SPC_ST_RUN);

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      state_reg <= SPC_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      sel_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // Edge detectors reset to the idle level of their pins
  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      good_d_reg <= 1'b0;
    end else begin
      good_d_reg <= good_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      event_d_reg <= 1'b0;
    end else begin
      event_d_reg <= event_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      button_d_reg <= 1'b0;
    end else begin
      button_d_reg <= button_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      ev_reg <= 1'b0;
    end else begin
      ev_reg <= ev_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      em_reg <= 1'b0;
    end else begin
      em_reg <= em_next;
    end
  end

  // Core reset independent of the power state machine
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      core_rst_reg <= 1'b1;
    end else begin
      core_rst_reg <= core_rst_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (full_rst) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
    end
  end

  assign o_supply_select = sel_reg;
  assign o_core_reset = core_rst_reg;
  assign o_running = run_reg;
  assign o_supply_event_pend = ev_reg;
  assign o_emergency_pend = em_reg;
endmodule

// file: spc_top_sva.sv
/* Port checker for spc_top.
   Assumes it is bound to spc_top. */
`timescale 1ns/1ps
module spc_top_sva (
  input wire logic i_clk, i_srst, i_core_reset_n, i_on_button,
  input wire logic i_supply_good, i_supply_event, o_supply_select,
  input wire logic o_core_reset, o_running, o_supply_event_pend,
  input wire logic o_emergency_pend
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_on; $rose(i_on_button) && i_supply_good && !o_running
    |-> ##[1:8] o_supply_select; endproperty
  a_on: assert property (p_on) else $error("late");
  property p_dead; !i_supply_good [*5] |-> !$rose(o_supply_select);
  endproperty
  a_dead: assert property (p_dead) else $error("no good");
  property p_evt; $rose(i_supply_event) |-> ##[1:4] o_supply_event_pend;
  endproperty
  a_evt: assert property (p_evt) else $error("event");
  property p_emg; o_running && $fell(i_supply_good)
    |-> ##[1:4] o_emergency_pend; endproperty
  a_emg: assert property (p_emg) else $error("emerg");
  property p_core; !i_core_reset_n [*4] |-> o_core_reset; endproperty
  a_core: assert property (p_core) else $error("core");
  property p_run; $rose(o_running) |-> $past(o_supply_select); endproperty
  a_run: assert property (p_run) else $error("run");
  property p_rst; $fell(i_srst) |-> !o_supply_select && !o_running
    && !o_supply_event_pend && !o_emergency_pend; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  c_run: cover property ($rose(o_running));
  c_evt: cover property ($rose(o_supply_event_pend));
  c_emg: cover property ($rose(o_emergency_pend));
endmodule
bind spc_top spc_top_sva u_spc_top_sva (.*);

// file: testbench.sv
/* Bench for spc_top with a supply model.
   Assumes the hand-over timing of the design. */
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'h0, i_srst = 1'h1, i_pon_n = 1'h0, i_core_reset_n = 1'h1;
  logic i_on_button = 1'h0, i_supply_good = 1'h0, i_supply_event = 1'h0;
  logic i_wake_irq = 1'h0, i_sleep_req = 1'h0, i_event_clear = 1'h0;
  logic i_emerg_clear = 1'h0, off = 1'h1, i_switched_rail_status;
  logic o_supply_select, o_core_reset, o_running;
  logic o_supply_event_pend, o_emergency_pend;
  int error_cnt = 0, n_compared = 0, cyc = 0, latches;
  always #12.5 i_clk = ~i_clk;
  spc_top u_spc_top (.*);
  spc_supply_model u_spc_supply_model (.i_clk(i_clk),
    .i_select(o_supply_select), .i_off(off),
    .o_rail(i_switched_rail_status), .o_latch_cnt(latches));
  task chk(string n, logic s, logic e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %b got %b", n, e, s);
    end
  endtask
  task finish_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cy(int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    cy(1);
    s = 1'h0;
  endtask
  task waitrun();
    for (int k = 0; k < 200 && o_running !== 1'h1; k++) cy(1);
  endtask
  task t_refuse();
    pulse(i_on_button);
    cy(9);
    chk("select", o_supply_select, 1'h0);
    chk("running", o_running, 1'h0);
    i_supply_good = 1'h1;
    off = 1'h0;
    cy(4);
  endtask
  task t_boot();
    i_on_button = 1'h1;
    cy(6);
    chk("select", o_supply_select, 1'h1);
    i_on_button = 1'h0;
    waitrun();
    chk("running", o_running, 1'h1);
    chk("select", o_supply_select, 1'h0);
    cy(1);
    chk("latch", latches == 1, 1'h1);
  endtask
  task t_evt();
    pulse(i_supply_event);
    cy(3);
    chk("event", o_supply_event_pend, 1'h1);
    pulse(i_event_clear);
    chk("event", o_supply_event_pend, 1'h0);
  endtask
  task t_core();
    i_core_reset_n = 1'h0;
    cy(5);
    chk("core", o_core_reset, 1'h1);
    i_core_reset_n = 1'h1;
    cy(5);
    chk("core", o_core_reset, 1'h0);
  endtask
  task t_sleep();
    pulse(i_sleep_req);
    off = 1'h1;
    cy(2);
    chk("running", o_running, 1'h0);
    off = 1'h0;
    pulse(i_wake_irq);
    waitrun();
    chk("running", o_running, 1'h1);
  endtask
  task t_emg_rst();
    pulse(i_supply_event);
    i_supply_good = 1'h0;
    cy(4);
    chk("emerg", o_emergency_pend, 1'h1);
    chk("event", o_supply_event_pend, 1'h1);
    pulse(i_emerg_clear);
    chk("emerg", o_emergency_pend, 1'h0);
    i_srst = 1'h1;
    cy(2);
    i_srst = 1'h0;
    chk("emerg", o_emergency_pend, 1'h0);
    chk("select", o_supply_select, 1'h0);
    chk("event", o_supply_event_pend, 1'h0);
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    cy(8);
    i_pon_n = 1'h1;
    cy(8);
    i_srst = 1'h0;
    cy(4);
    t_refuse();
    t_boot();
    t_evt();
    t_core();
    t_sleep();
    t_emg_rst();
    finish_test();
  end
endmodule
